/* src/int_div_pkg.sv */
// Constants, types and register map of the integer output divider.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package int_div_pkg;

  // Register indices and byte addresses (byte address is four times index)
  localparam int         IDX_RATIO = 'h0;
  localparam int         IDX_PHASE = 'h4;
  localparam int         IDX_CFG   = 'h6;
  localparam int         IDX_TRIG  = 'h8;
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] ADDR_RATIO = 8'(4 * IDX_RATIO);
  localparam logic [7:0] ADDR_PHASE = 8'(4 * IDX_PHASE);
  localparam logic [7:0] ADDR_CFG   = 8'(4 * IDX_CFG);
  localparam logic [7:0] ADDR_TRIG  = 8'(4 * IDX_TRIG);

  // Field widths and positions
  localparam int RATIO_W   = 23;
  localparam int PHASE_W   = 16;
  localparam int CFG_W     = 8;
  localparam int CFG_DLY   = 5;
  localparam int CFG_POST  = 4;
  localparam int CFG_SEL   = 0;
  localparam int SEL_W     = 3;
  localparam int TRIG_BIT  = 0;
  localparam int CNT_W     = RATIO_W + 1;

  // Reset values
  localparam logic [RATIO_W-1:0] RATIO_RST = 23'h000028;
  localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
  localparam logic [CFG_W-1:0]   CFG_RST   = 8'h10;
  localparam logic               TRIG_RST  = 1'b0;

  // Smallest ratio the counter can honour
  localparam logic [RATIO_W-1:0] RATIO_MIN = 23'h000002;

  // Instances on which the source select is honoured
  localparam int SEL_FIRST_INST = 6;
  localparam int SEL_LAST_INST  = 11;
  localparam int NUM_SRC        = 6;

  // Delay settings of the output delay cell, in picoseconds
  localparam int DELAY_SHORT_PS = 50;
  localparam int DELAY_LONG_PS  = 100;

  typedef enum logic [2:0] {
    SRC_VCO   = 3'b000,
    SRC_FRAC0 = 3'b001,
    SRC_FRAC1 = 3'b010,
    SRC_FRAC2 = 3'b011,
    SRC_TSYNC = 3'b100,
    SRC_TCLK  = 3'b101,
    SRC_RSV6  = 3'b110,
    SRC_RSV7  = 3'b111
  } src_sel_t;

  typedef enum logic [1:0] {
    DLY_NONE  = 2'b00,
    DLY_SHORT = 2'b10,
    DLY_LONG  = 2'b11
  } dly_code_t;

  typedef struct packed {
    logic     delay_en;
    logic     post_sync;
    src_sel_t sel;
  } div_cfg_t;

endpackage : int_div_pkg

/* src/int_out_divider.sv */
// Integer output divider with phase stepping, APB register slave.
// Assumes source clocks and resync arrive asynchronously on pins and are
// far slower than pclk; driver enable and delay select come from pclk logic.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

// Behaviour
// RULE_01 - Divide source by 23-bit ratio, reset forty
// RULE_02 - Signed step count; positive advances, negative delays
// RULE_03 - One step equals one selected source period
// RULE_04 - Trigger write applies programmed phase step count
// RULE_05 - Trigger reads one until adjustment done
// RULE_06 - After-resync flag applies step after resync
// RULE_07 - Three-bit source select picks input clock
// RULE_08 - Source select honoured on instances six-eleven
// RULE_09 - Extra delay enable adds output delay
// RULE_10 - Software never triggers while driver disabled
// RULE_11 - Delay select gives 50 or 100 ps
// RULE_12 - Reserved bits read zero, writes ignored
module int_out_divider #(
  parameter int INSTANCE = 0
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Source clocks and resync from outside
  input  wire logic [5:0]  src_clk_in,
  input  wire logic        resync_in,
  // Output driver controls from pclk logic
  input  wire logic        out_driver_en,
  input  wire logic        out_delay_sel,
  // Toward the output driver
  output logic             div_clk_out,
  output logic [1:0]       delay_code_out
);

  // Registers
  logic [int_div_pkg::RATIO_W-1:0] ratio_r;
  logic [int_div_pkg::PHASE_W-1:0] phase_r;
  int_div_pkg::div_cfg_t           cfg_r;
  logic                            trig_r;
  logic signed [int_div_pkg::PHASE_W-1:0] rem_r;
  logic [int_div_pkg::CNT_W-1:0]   cnt_r;
  logic [int_div_pkg::CNT_W-1:0]   cnt_nxt;
  logic [31:0]                     prdata_r;
  logic                            pready_r;
  logic                            pslverr_r;
  logic                            clk_out_r;
  logic [1:0]                      delay_code_r;

  // Synchronisers: six sources and resync
  logic [6:0] raw_in;
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic [6:0] sync3_r;
  logic [6:0] rise;

  assign raw_in = {resync_in, src_clk_in};

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          sync3_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= raw_in[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
        end
      end
      assign rise[g] = sync2_r[g] & ~sync3_r[g];
    end
  endgenerate

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Bus decode
  wire setup   = psel & ~penable;
  wire wr_en   = psel & penable & pwrite & pready_r;
  wire hit_rat = (paddr == int_div_pkg::ADDR_RATIO);
  wire hit_ph  = (paddr == int_div_pkg::ADDR_PHASE);
  wire hit_cfg = (paddr == int_div_pkg::ADDR_CFG);
  wire hit_trg = (paddr == int_div_pkg::ADDR_TRIG);
  wire mapped  = hit_rat | hit_ph | hit_cfg | hit_trg;

  // Config word in its bus layout, shared by read and byte merge
  wire [31:0] cfg_word = {26'h0, cfg_r.delay_en, cfg_r.post_sync, 1'b0,
                          cfg_r.sel}; // RULE_12
  wire [31:0] ratio_m  = merge({9'h0, ratio_r}, pwdata, pstrb);
  wire [31:0] phase_m  = merge({16'h0000, phase_r}, pwdata, pstrb);
  wire [31:0] cfg_m    = merge(cfg_word, pwdata, pstrb);

  wire trig_set = wr_en & hit_trg & pstrb[0] & pwdata[int_div_pkg::TRIG_BIT];

  // Read data; reserved bits zero
  logic [31:0] rd_word;
  always_comb begin
    if (hit_rat)
      rd_word = {9'h0, ratio_r};
    else if (hit_ph)
      rd_word = {16'h0000, phase_r};
    else if (hit_cfg)
      rd_word = cfg_word; // RULE_12
    else if (hit_trg)
      rd_word = {31'h0, trig_r};
    else
      rd_word = 32'h00000000;
  end

  // APB answer: one wait-free access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (setup && !pwrite) ? rd_word : 32'h00000000;
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
    end
  end

  // Configuration registers; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_r <= int_div_pkg::RATIO_RST;
      phase_r <= int_div_pkg::PHASE_RST;
      cfg_r   <= '{delay_en:  int_div_pkg::CFG_RST[int_div_pkg::CFG_DLY],
                   post_sync: int_div_pkg::CFG_RST[int_div_pkg::CFG_POST],
                   sel: int_div_pkg::src_sel_t'(int_div_pkg::CFG_RST[2:0])};
    end else if (wr_en) begin
      if (hit_rat)
        ratio_r <= ratio_m[int_div_pkg::RATIO_W-1:0]; // RULE_01
      if (hit_ph)
        phase_r <= phase_m[int_div_pkg::PHASE_W-1:0];
      if (hit_cfg) begin
        cfg_r.delay_en  <= cfg_m[int_div_pkg::CFG_DLY];
        cfg_r.post_sync <= cfg_m[int_div_pkg::CFG_POST];
        cfg_r.sel <= int_div_pkg::src_sel_t'(cfg_m[2:0]); // RULE_07
      end
    end
  end

  // Source selection
  localparam bit SEL_ACTIVE = (INSTANCE >= int_div_pkg::SEL_FIRST_INST) &&
                              (INSTANCE <= int_div_pkg::SEL_LAST_INST);
  wire int_div_pkg::src_sel_t eff_sel =
    SEL_ACTIVE ? cfg_r.sel : int_div_pkg::SRC_VCO; // RULE_08
  wire sel_ok  = (eff_sel != int_div_pkg::SRC_RSV6) &&
                 (eff_sel != int_div_pkg::SRC_RSV7);
  wire src_edge = sel_ok & rise[eff_sel]; // RULE_07

  // One tick per source period is one phase step
  wire tick      = src_edge & out_driver_en; // RULE_03
  wire resync_ev = rise[6];
  wire load      = trig_set | (resync_ev & cfg_r.post_sync); // RULE_06

  // Counter arithmetic
  wire [int_div_pkg::RATIO_W-1:0] ratio_eff =
    (ratio_r < int_div_pkg::RATIO_MIN) ? int_div_pkg::RATIO_MIN : ratio_r;
  wire [int_div_pkg::CNT_W-1:0] ratio_c = {1'b0, ratio_eff};
  wire [int_div_pkg::CNT_W-1:0] half_c  = {2'b00, ratio_eff[22:1]};
  wire [int_div_pkg::CNT_W-1:0] cnt_p1  = cnt_r + 24'h000001;
  wire [int_div_pkg::CNT_W-1:0] cnt_p2  = cnt_r + 24'h000002;
  wire [int_div_pkg::CNT_W-1:0] cnt_one =
    (cnt_p1 >= ratio_c) ? 24'h000000 : cnt_p1;
  wire [int_div_pkg::CNT_W-1:0] cnt_two =
    (cnt_r >= ratio_c) ? 24'h000000 :
    (cnt_p2 >= ratio_c) ? cnt_p2 - ratio_c : cnt_p2;

  always_comb begin
    if (resync_ev)
      cnt_nxt = 24'h000000;
    else if (!tick)
      cnt_nxt = cnt_r;
    else if (rem_r > 0)
      cnt_nxt = cnt_two; // RULE_02
    else if (rem_r < 0)
      cnt_nxt = cnt_r; // RULE_02
    else
      cnt_nxt = cnt_one; // RULE_01
  end

  // Divider, step engine and trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 24'h000000;
      rem_r     <= 16'sh0000;
      trig_r    <= int_div_pkg::TRIG_RST;
      clk_out_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      clk_out_r <= out_driver_en & (cnt_nxt < half_c);
      if (load)
        rem_r <= signed'(phase_r); // RULE_04
      else if (tick && !resync_ev && rem_r > 0)
        rem_r <= rem_r - 16'sh0001;
      else if (tick && !resync_ev && rem_r < 0)
        rem_r <= rem_r + 16'sh0001;
      if (trig_set)
        trig_r <= 1'b1; // RULE_05
      else if (rem_r == 0 && !load)
        trig_r <= 1'b0; // RULE_05
    end
  end

  // Output delay cell control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      delay_code_r <= int_div_pkg::DLY_NONE;
    else if (!cfg_r.delay_en)
      delay_code_r <= int_div_pkg::DLY_NONE; // RULE_09
    else if (out_delay_sel)
      delay_code_r <= int_div_pkg::DLY_LONG; // RULE_11
    else
      delay_code_r <= int_div_pkg::DLY_SHORT; // RULE_11
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign div_clk_out    = clk_out_r;
  assign delay_code_out = delay_code_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cnt_range;
    (tick && !resync_ev && !wr_en) |=> (cnt_r < $past(ratio_c));
  endproperty
  a_cnt_range: assert property (p_cnt_range) // RULE_01
    else $error("divider count out of range");

  property p_advance;
    (tick && !resync_ev && !load && rem_r > 0) |=>
      (rem_r == $past(rem_r) - 16'sh0001) && (cnt_r != $past(cnt_p1) ||
       $past(cnt_p1) >= $past(ratio_c));
  endproperty
  a_advance: assert property (p_advance) // RULE_02
    else $error("positive step did not advance");

  property p_retard;
    (tick && !resync_ev && !load && rem_r < 0) |=>
      (cnt_r == $past(cnt_r)) && (rem_r == $past(rem_r) + 16'sh0001);
  endproperty
  a_retard: assert property (p_retard) // RULE_02
    else $error("negative step did not hold the count");

  property p_trig_load;
    trig_set |=> trig_r && (rem_r == signed'($past(phase_r)));
  endproperty
  a_trig_load: assert property (p_trig_load) // RULE_04
    else $error("trigger did not load the step count");

  property p_trig_hold;
    (trig_r && rem_r != 0) |=> trig_r;
  endproperty
  a_trig_hold: assert property (p_trig_hold) // RULE_05
    else $error("trigger cleared before adjustment ended");

  property p_trig_clear;
    (trig_r && rem_r == 0 && !load) |=> !trig_r;
  endproperty
  a_trig_clear: assert property (p_trig_clear) // RULE_05
    else $error("trigger stuck after adjustment ended");

  property p_post_sync;
    (resync_ev && !trig_set) |=>
      (rem_r == ($past(cfg_r.post_sync) ? signed'($past(phase_r))
                                        : $past(rem_r))) && cnt_r == 0;
  endproperty
  a_post_sync: assert property (p_post_sync) // RULE_06
    else $error("resync step handling wrong");

  property p_delay;
    ##1 delay_code_out == (!$past(cfg_r.delay_en) ? int_div_pkg::DLY_NONE :
      $past(out_delay_sel) ? int_div_pkg::DLY_LONG : int_div_pkg::DLY_SHORT);
  endproperty
  a_delay: assert property (p_delay) // RULE_09
    else $error("delay code does not follow configuration");

  property p_rsv_zero;
    (setup && !pwrite && hit_cfg) |=>
      pready && prdata[31:6] == 26'h0 && !prdata[3];
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // RULE_12
    else $error("reserved bits read nonzero");

  property p_unmapped;
    (setup && !mapped) |=> pready && pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

endmodule : int_out_divider

/* sim/tb_integer_output_divider_phase_adjust.sv */
// Self-checking bench of the integer output divider, APB side and clock.
// Assumes int_div_pkg and int_out_divider are compiled before it.
`timescale 1ns/1ps
module tb_integer_output_divider_phase_adjust;
  localparam logic [7:0] A_R = int_div_pkg::ADDR_RATIO;
  localparam logic [7:0] A_P = int_div_pkg::ADDR_PHASE;
  localparam logic [7:0] A_C = int_div_pkg::ADDR_CFG;
  localparam logic [7:0] A_T = int_div_pkg::ADDR_TRIG;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        drv_en, dly_sel, resync, div_clk, src_run, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [5:0]  src;
  logic [1:0]  dly_code;
  logic [2:0]  src_idx, ph;
  int          error_cnt, total_checks, cyc, n, t0, t1;

  int_out_divider #(.INSTANCE(6)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_clk_in(src), .resync_in(resync),
    .out_driver_en(drv_en), .out_delay_sel(dly_sel),
    .div_clk_out(div_clk), .delay_code_out(dly_code)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Source tick every 6 pclk cycles; hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ph  <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
    src <= (src_run && ph < 3'h3) ? 6'h01 << src_idx : 6'h00;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait until pready is high; only the bench timeout ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf);
    check(rd, e);
  endtask : rchk

  // Cycles until the next rising edge of the divided clock, 400 if none
  task automatic rise(output int c);
    logic p;
    c = 0;
    p = 1'b1;
    while (!(p === 1'b0 && div_clk === 1'b1) && c < 400) begin
      p = div_clk;
      @(posedge pclk);
      c++;
    end
  endtask : rise

  task automatic t_regs();
    rchk(A_R, 32'h00000028);
    rchk(A_P, 32'h00000000);
    rchk(A_C, 32'h00000010);
    rchk(A_T, 32'h00000000);
    rchk(8'h04, 32'h00000000);
    check({31'h0, err}, 32'h1);
    wr(A_R, 32'hffffffff);
    rchk(A_R, 32'h007fffff);
    apb(1'b1, A_R, 32'h00000004, 4'h1);
    rchk(A_R, 32'h007fff04);
    wr(A_P, 32'hffffffff);
    rchk(A_P, 32'h0000ffff);
    wr(A_C, 32'hffffffff);
    rchk(A_C, 32'h00000037);
    wr(A_R, 32'h00000004);
    wr(A_C, 32'h00000010);
    $display("test registers done");
  endtask : t_regs

  task automatic t_sel();
    for (int k = 0; k < 6; k++) begin
      wr(A_C, 32'h00000010 | k);
      src_idx <= k[2:0];
      // Period right after a switch may hold a stray tick
      repeat (2) rise(n);
      rise(n);
      check(n, 24);
    end
    wr(A_C, 32'h00000016);
    // Let any edge launched before the switch settle
    repeat (2) @(posedge pclk);
    rise(n);
    check(n, 400);
    wr(A_C, 32'h00000010);
    src_idx <= 3'h0;
    $display("test source select done");
  endtask : t_sel

  // Driver stays enabled whenever a step is triggered
  task automatic t_step(input logic [31:0] s, input int e);
    wr(A_P, s);
    rise(n);
    t0 = cyc;
    wr(A_T, 32'h00000001);
    rchk(A_T, 32'h00000001);
    repeat (3) rise(n);
    check(cyc - t0, e);
    rchk(A_T, 32'h00000000);
    $display("test phase step done");
  endtask : t_step

  task automatic sync_len(output int c);
    rise(n);
    resync <= 1'b1;
    repeat (4) @(posedge pclk);
    resync <= 1'b0;
    c = cyc;
    repeat (2) rise(n);
    c = cyc - c;
  endtask : sync_len

  task automatic t_resync();
    wr(A_P, 32'h00000002);
    wr(A_C, 32'h00000000);
    sync_len(t1);
    wr(A_C, 32'h00000010);
    sync_len(t0);
    check(t1 - t0, 12);
    $display("test resync done");
  endtask : t_resync

  task automatic t_dly();
    for (int i = 0; i < 4; i++) begin
      wr(A_C, 32'h00000010 | (i[1] << 5));
      dly_sel <= i[0];
      repeat (4) @(posedge pclk);
      check(dly_code, i[1] ? {1'b1, i[0]} : 2'b00);
    end
    // Driver disabled: output held low
    drv_en <= 1'b0;
    repeat (30) @(posedge pclk);
    check(div_clk, 1'b0);
    drv_en <= 1'b1;
    $display("test delay done");
  endtask : t_dly

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    {presetn, psel, penable, pwrite, resync, dly_sel} = 6'h00;
    {paddr, pwdata, pstrb, cyc, ph, src} = '0;
    {error_cnt, total_checks, src_idx} = '0;
    drv_en  = 1'b1;
    src_run = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sel();
    t_step(32'h00000002, 60);
    t_step(32'h0000fffe, 84);
    t_resync();
    t_dly();
    end_sim();
  end
endmodule : tb_integer_output_divider_phase_adjust
